// ===== bench/dmrt_checker.sv
// port-level assertions for the dual mode reload timer
`timescale 1ns/1ps
module dmrt_checker (
    // clock and reset
    input wire        CORE_CLK_IN,
    input wire        RST_IN,
    // apb
    input wire        PSEL_IN,
    input wire        PENABLE_IN,
    input wire        PWRITE_IN,
    input wire [11:0] PADDR_IN,
    input wire [31:0] PRDATA_OUT,
    input wire        PREADY_OUT,
    input wire        PSLVERR_OUT,
    // interrupts
    input wire        TIMER_IRQ_OUT,
    input wire        MASKED_IRQ_OUT
);
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);
    // a completed write, the only thing allowed to lower an irq
    wire wr_done = PREADY_OUT && PWRITE_IN;
    wire mapped  = (PADDR_IN <= 12'h020) && (PADDR_IN[1:0] == 2'b00);

    ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready longer than one cycle");
    ready_cause_a: assert property ($rose(PSEL_IN && PENABLE_IN) |=> PREADY_OUT)
        else $error("ready not one cycle after access");
    ready_only_a: assert property (PREADY_OUT |-> PSEL_IN && PENABLE_IN)
        else $error("ready outside an access");
    err_unmapped_a: assert property (PREADY_OUT && !mapped |-> PSLVERR_OUT)
        else $error("unmapped access without error");
    err_mapped_a: assert property (PREADY_OUT && mapped |-> !PSLVERR_OUT)
        else $error("mapped access with error");
    err_zero_a: assert property (PSLVERR_OUT |-> PREADY_OUT && PRDATA_OUT == 0)
        else $error("error response carries data");
    byte_lane_a: assert property (PREADY_OUT |-> PRDATA_OUT[31:8] == 24'h0)
        else $error("upper read lanes not zero");
    ctrl_gap_a: assert property (PREADY_OUT && !PWRITE_IN && PADDR_IN == 0
        |-> PRDATA_OUT[4] == 1'b0 && PRDATA_OUT[1] == 1'b0)
        else $error("unused control bits read one");
    irq_sticky_a: assert property ($fell(TIMER_IRQ_OUT)
        |-> $past(wr_done, 1) || $past(wr_done, 2))
        else $error("timer irq dropped without a write");
    mirq_sticky_a: assert property ($fell(MASKED_IRQ_OUT)
        |-> $past(wr_done, 1) || $past(wr_done, 2))
        else $error("masked irq dropped without a write");

    cover property (PSLVERR_OUT);
    cover property ($rose(TIMER_IRQ_OUT));
    cover property ($rose(MASKED_IRQ_OUT));
endmodule // dmrt_checker

bind dmrt_timer dmrt_checker dmrt_checker_i (
    .CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .TIMER_IRQ_OUT(TIMER_IRQ_OUT),
    .MASKED_IRQ_OUT(MASKED_IRQ_OUT));

// ===== bench/testbench.sv
// register-level testbench for the dual mode reload timer
`timescale 1ns/1ps
`include "dmrt_consts.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module testbench;
    reg         clk = 0, rst = 1, sel = 0, en = 0, wr = 0, osc = 0;
    reg         ce = 1;
    reg  [11:0] addr = 0;
    reg  [31:0] wdat = 0, rdat;
    reg         rerr;
    wire [31:0] prdata;
    wire        pready, pslverr, tirq, mirq;
    int         err_total = 0, n_tests = 0, i;

    dmrt_timer dmrt_timer_i (
        .CORE_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .PSEL_IN(sel),
        .PENABLE_IN(en), .PWRITE_IN(wr), .PADDR_IN(addr), .PWDATA_IN(wdat),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .EXT_OSC_IN(osc), .TIMER_IRQ_OUT(tirq), .MASKED_IRQ_OUT(mirq));

    // 50 MHz core clock
    always #10 clk = ~clk;
    // external oscillator, eight core cycles a period
    always @(posedge clk) begin
        if ($time % 80 < 20) osc <= ~osc;
    end

    // one apb transfer: setup, access until ready
    task apb(input w, input [11:0] a, input [7:0] d);
        int k;
        @(posedge clk);
        sel <= 1; en <= 0; wr <= w; addr <= a; wdat <= {24'h0, d};
        @(posedge clk);
        en <= 1;
        // look between edges so ready and data are settled
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) `CHK(pready, 1'b1)
        rdat = prdata;
        rerr = pslverr;
        // hold through the edge at which ready is sampled high
        @(posedge clk);
        sel <= 0; en <= 0;
    endtask
    task rc(input [11:0] a, input [7:0] e);
        apb(0, a, 8'h00);
        `CHK(rdat, {24'h0, e})
    endtask
    task wait_irq;
        int k;
        for (k = 0; k < 400 && tirq !== 1'b1; k++) @(negedge clk);
        `CHK(tirq, 1'b1)
    endtask
    // free count of the low byte in split mode under one clock choice
    task rate(input [7:0] c, input [7:0] s, input int t, lo, hi);
        // stop the byte first so the count write is not lost to a step
        apb(1, `DMRT_OFF_CTRL, 8'h00);
        apb(1, `DMRT_OFF_CLKSEL, s);
        apb(1, `DMRT_OFF_CNT_LO, 8'h00);
        apb(1, `DMRT_OFF_CTRL, c);
        repeat (t) @(posedge clk);
        apb(0, `DMRT_OFF_CNT_LO, 8'h00);
        `CHK(rdat[7:0] >= lo && rdat[7:0] <= hi, 1'b1)
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #400000;
        err_total++;
        stop_test;
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 0;
        // reset values and the refused address
        for (i = 0; i < 9; i++) rc(i * 4, 8'h00);
        apb(1, 12'h024, 8'hFF);
        rc(12'h024, 8'h00);
        `CHK(rerr, 1'b1)
        $display("test reset done");
        // 16-bit overflow and reload
        apb(1, `DMRT_OFF_RLD_LO, 8'h34);
        apb(1, `DMRT_OFF_RLD_HI, 8'h12);
        apb(1, `DMRT_OFF_CNT_LO, 8'hFE);
        apb(1, `DMRT_OFF_CNT_HI, 8'hFF);
        apb(1, `DMRT_OFF_CLKSEL, 8'h01);
        apb(1, `DMRT_OFF_IRQ_EN, 8'h01);
        apb(1, `DMRT_OFF_CTRL, 8'h04);
        wait_irq;
        apb(1, `DMRT_OFF_CTRL, 8'hC0);
        rc(`DMRT_OFF_CNT_HI, 8'h12);
        apb(0, `DMRT_OFF_CNT_LO, 8'h00);
        `CHK(rdat[7:0] >= 8'h34 && rdat[7:0] < 8'h50, 1'b1)
        rc(`DMRT_OFF_CTRL, 8'hC0);
        rc(`DMRT_OFF_IRQ_STAT, 8'h03);
        repeat (50) @(posedge clk);
        rc(`DMRT_OFF_CTRL, 8'hC0);
        apb(1, `DMRT_OFF_IRQ_MASK, 8'h02);
        repeat (3) @(posedge clk);
        `CHK(mirq, 1'b1)
        apb(1, `DMRT_OFF_IRQ_STAT, 8'h02);
        rc(`DMRT_OFF_IRQ_STAT, 8'h01);
        `CHK(mirq, 1'b0)
        apb(1, `DMRT_OFF_CTRL, 8'h00);
        repeat (3) @(posedge clk);
        `CHK(tirq, 1'b0)
        $display("test 16-bit done");
        // split low byte: runs without run bit, irq only with low enable
        apb(1, `DMRT_OFF_RLD_LO, 8'hF0);
        apb(1, `DMRT_OFF_CNT_HI, 8'h55);
        apb(1, `DMRT_OFF_CLKSEL, 8'h00);
        apb(1, `DMRT_OFF_CNT_LO, 8'hFD);
        apb(1, `DMRT_OFF_CTRL, 8'h08);
        repeat (60) @(posedge clk);
        apb(0, `DMRT_OFF_CNT_LO, 8'h00);
        `CHK(rdat[7:4], 4'hF)
        rc(`DMRT_OFF_CNT_HI, 8'h55);
        rc(`DMRT_OFF_CTRL, 8'h48);
        `CHK(tirq, 1'b0)
        apb(1, `DMRT_OFF_CTRL, 8'h68);
        repeat (3) @(posedge clk);
        `CHK(tirq, 1'b1)
        // split high byte on the core clock with run
        apb(1, `DMRT_OFF_RLD_HI, 8'hA0);
        apb(1, `DMRT_OFF_CNT_HI, 8'hFE);
        apb(1, `DMRT_OFF_CLKSEL, 8'h02);
        apb(1, `DMRT_OFF_CTRL, 8'h0C);
        wait_irq;
        apb(0, `DMRT_OFF_CNT_HI, 8'h00);
        `CHK(rdat[7:4], 4'hA)
        apb(0, `DMRT_OFF_CTRL, 8'h00);
        `CHK(rdat[7:0] & 8'hBF, 8'h8C)
        $display("test split done");
        // clock choices for the low byte
        rate(8'h08, 8'h01, 20, 20, 28);
        rate(8'h08, 8'h00, 120, 9, 12);
        rate(8'h09, 8'h00, 520, 7, 9);
        // clock enable low freezes the running low byte
        rate(8'h08, 8'h01, 0, 0, 8);
        apb(1, `DMRT_OFF_CTRL, 8'h00);
        apb(1, `DMRT_OFF_CNT_LO, 8'h00);
        apb(1, `DMRT_OFF_CTRL, 8'h08);
        ce <= 0;
        repeat (30) @(posedge clk);
        ce <= 1;
        apb(0, `DMRT_OFF_CNT_LO, 8'h00);
        `CHK(rdat[7:0] >= 1 && rdat[7:0] <= 8, 1'b1)
        $display("test clocks done");
        stop_test;
    end
endmodule // testbench

// ===== inc/dmrt_consts.vh
// register offsets, field positions, reset values and timing counts
`ifndef DMRT_CONSTS_VH
`define DMRT_CONSTS_VH

// apb byte addresses
`define DMRT_OFF_CTRL      12'h000
`define DMRT_OFF_CNT_LO    12'h004
`define DMRT_OFF_CNT_HI    12'h008
`define DMRT_OFF_RLD_LO    12'h00C
`define DMRT_OFF_RLD_HI    12'h010
`define DMRT_OFF_CLKSEL    12'h014
`define DMRT_OFF_IRQ_EN    12'h018
`define DMRT_OFF_IRQ_STAT  12'h01C
`define DMRT_OFF_IRQ_MASK  12'h020

// timer control register fields
`define DMRT_CTRL_HOVF     7
`define DMRT_CTRL_LOVF     6
`define DMRT_CTRL_LIEN     5
`define DMRT_CTRL_SPLIT    3
`define DMRT_CTRL_RUN      2
`define DMRT_CTRL_XCLK     0
// writable control bits (flags handled separately)
`define DMRT_CTRL_WMASK    8'h2D

// clock select register fields
`define DMRT_CKS_HIGH      1
`define DMRT_CKS_LOW       0

// interrupt enable register field
`define DMRT_IE_TIMER      0

// status register layout
`define DMRT_ST_HOVF       1
`define DMRT_ST_LOVF       0

// reset values
`define DMRT_RST_BYTE      8'h00

// divider ratios
`define DMRT_CORE_DIV      12
`define DMRT_EXT_DIV       8

`endif

// ===== rtl/dmrt_sync.v
// three-stage synchroniser with agreement filter on the last two stages
`timescale 1ns/1ps
module dmrt_sync (
    // clocking
    input  wire clk_in,
    input  wire rst_in,
    input  wire ce_in,
    // async level in, filtered level out
    input  wire async_in,
    output reg  level_out
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // shift chain; level changes only when stages 2 and 3 agree
    always @(posedge clk_in) begin
        if (rst_in) begin
            s1_q      <= 1'b0;
            s2_q      <= 1'b0;
            s3_q      <= 1'b0;
            level_out <= 1'b0;
        end else if (ce_in) begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_out <= s3_q;
            end
        end
    end
endmodule // dmrt_sync

// ===== rtl/dmrt_ticks.v
// tick generators: core clock divided by 12, external clock divided by 8
`timescale 1ns/1ps
`include "dmrt_consts.vh"
module dmrt_ticks #(
    parameter CORE_DIV = `DMRT_CORE_DIV,
    parameter EXT_DIV  = `DMRT_EXT_DIV
) (
    // clocking
    input  wire clk_in,
    input  wire rst_in,
    input  wire ce_in,
    // synchronised external oscillator level
    input  wire ext_level_in,
    // one-cycle ticks
    output reg  div12_tick_out,
    output reg  ext8_tick_out
);
    reg [3:0] core_cnt_q;
    reg [2:0] ext_cnt_q;
    reg       ext_prev_q;

    // prescaler on the core clock
    always @(posedge clk_in) begin
        if (rst_in) begin
            core_cnt_q     <= 4'h0;
            div12_tick_out <= 1'b0;
        end else if (ce_in) begin
            div12_tick_out <= (core_cnt_q == CORE_DIV - 1);
            if (core_cnt_q == CORE_DIV - 1) begin
                core_cnt_q <= 4'h0;
            end else begin
                core_cnt_q <= core_cnt_q + 4'h1;
            end
        end
    end

    // count rising edges of the synced external clock, tick every eighth
    always @(posedge clk_in) begin
        if (rst_in) begin
            ext_cnt_q     <= 3'h0;
            ext_prev_q    <= 1'b0;
            ext8_tick_out <= 1'b0;
        end else if (ce_in) begin
            ext_prev_q    <= ext_level_in;
            ext8_tick_out <= 1'b0;
            if (ext_level_in && !ext_prev_q) begin
                if (ext_cnt_q == EXT_DIV - 1) begin
                    ext_cnt_q     <= 3'h0;
                    ext8_tick_out <= 1'b1;
                end else begin
                    ext_cnt_q <= ext_cnt_q + 3'h1;
                end
            end
        end
    end
endmodule // dmrt_ticks

// ===== rtl/dmrt_timer.v
// dual mode reload timer with apb register access and interrupt outputs
`timescale 1ns/1ps
`include "dmrt_consts.vh"
module dmrt_timer (
    // clock, reset, enable
    input  wire        CORE_CLK_IN,
    input  wire        RST_IN,
    input  wire        CE_IN,
    // apb slave
    input  wire        PSEL_IN,
    input  wire        PENABLE_IN,
    input  wire        PWRITE_IN,
    input  wire [11:0] PADDR_IN,
    input  wire [31:0] PWDATA_IN,
    output reg  [31:0] PRDATA_OUT,
    output reg         PREADY_OUT,
    output reg         PSLVERR_OUT,
    // external oscillator pin
    input  wire        EXT_OSC_IN,
    // interrupts
    output reg         TIMER_IRQ_OUT,
    output reg         MASKED_IRQ_OUT
);
    // register state
    reg [7:0] count_low_byte_q;
    reg [7:0] count_high_byte_q;
    reg [7:0] reload_low_byte_q;
    reg [7:0] reload_high_byte_q;
    reg [7:0] ctrl_q;           // writable control bits
    reg       high_overflow_flag_q;
    reg       low_overflow_flag_q;
    reg       high_clock_select_q;
    reg       low_clock_select_q;
    reg       timer_irq_enable_q;
    reg [1:0] irq_stat_q;
    reg [1:0] irq_mask_q;

    wire       ext_level;
    wire       div12_tick;
    wire       ext8_tick;

    // external oscillator into the core clock domain
    dmrt_sync u_sync (
        .clk_in    (CORE_CLK_IN),
        .rst_in    (RST_IN),
        .ce_in     (CE_IN),
        .async_in  (EXT_OSC_IN),
        .level_out (ext_level)
    );

    // prescalers
    dmrt_ticks u_ticks (
        .clk_in         (CORE_CLK_IN),
        .rst_in         (RST_IN),
        .ce_in          (CE_IN),
        .ext_level_in   (ext_level),
        .div12_tick_out (div12_tick),
        .ext8_tick_out  (ext8_tick)
    );

    // pick one tick: core clock when sel set, else divider by xclk bit
    function pick_tick;
        input sel;
        input xclk;
        input d12;
        input e8;
        begin
            if (sel) begin
                pick_tick = 1'b1;
            end else if (xclk) begin
                pick_tick = e8;
            end else begin
                pick_tick = d12;
            end
        end
    endfunction

    // control decode
    wire split_mode_select     = ctrl_q[`DMRT_CTRL_SPLIT];
    wire run_control           = ctrl_q[`DMRT_CTRL_RUN];
    wire external_clock_select = ctrl_q[`DMRT_CTRL_XCLK];
    wire low_overflow_irq_enable = ctrl_q[`DMRT_CTRL_LIEN];

    // tick per byte; in 16-bit mode the low select drives both
    wire low_tick  = pick_tick(low_clock_select_q, external_clock_select,
                               div12_tick, ext8_tick);
    wire high_tick = pick_tick(high_clock_select_q, external_clock_select,
                               div12_tick, ext8_tick);

    wire [15:0] count_word = {count_high_byte_q, count_low_byte_q};
    wire [15:0] reload_word = {reload_high_byte_q, reload_low_byte_q};

    // enables per byte
    wire low_step  = split_mode_select ? low_tick : (low_tick && run_control);
    wire high_step = split_mode_select ? (high_tick && run_control) : 1'b0;

    // wrap events
    wire low_wrap  = low_step && (count_low_byte_q == 8'hFF);
    wire ovf16     = !split_mode_select && low_wrap &&
                     (count_high_byte_q == 8'hFF);
    wire high_wrap = split_mode_select ?
                     (high_step && (count_high_byte_q == 8'hFF)) : ovf16;

    // apb decode
    wire apb_acc   = PSEL_IN && PENABLE_IN && PREADY_OUT;
    wire apb_wr    = apb_acc && PWRITE_IN;
    wire addr_ok   = (PADDR_IN == `DMRT_OFF_CTRL)    ||
                     (PADDR_IN == `DMRT_OFF_CNT_LO)  ||
                     (PADDR_IN == `DMRT_OFF_CNT_HI)  ||
                     (PADDR_IN == `DMRT_OFF_RLD_LO)  ||
                     (PADDR_IN == `DMRT_OFF_RLD_HI)  ||
                     (PADDR_IN == `DMRT_OFF_CLKSEL)  ||
                     (PADDR_IN == `DMRT_OFF_IRQ_EN)  ||
                     (PADDR_IN == `DMRT_OFF_IRQ_STAT)||
                     (PADDR_IN == `DMRT_OFF_IRQ_MASK);
    wire [7:0] wb  = PWDATA_IN[7:0];

    wire wr_ctrl   = apb_wr && (PADDR_IN == `DMRT_OFF_CTRL);
    wire wr_cnt_lo = apb_wr && (PADDR_IN == `DMRT_OFF_CNT_LO);
    wire wr_cnt_hi = apb_wr && (PADDR_IN == `DMRT_OFF_CNT_HI);
    wire wr_stat   = apb_wr && (PADDR_IN == `DMRT_OFF_IRQ_STAT);

    // read mux
    reg [7:0] rd_byte;
    always @* begin
        rd_byte = 8'h00;
        case (PADDR_IN)
            `DMRT_OFF_CTRL: begin
                rd_byte = ctrl_q;
                rd_byte[`DMRT_CTRL_HOVF] = high_overflow_flag_q;
                rd_byte[`DMRT_CTRL_LOVF] = low_overflow_flag_q;
            end
            `DMRT_OFF_CNT_LO:   rd_byte = count_low_byte_q;
            `DMRT_OFF_CNT_HI:   rd_byte = count_high_byte_q;
            `DMRT_OFF_RLD_LO:   rd_byte = reload_low_byte_q;
            `DMRT_OFF_RLD_HI:   rd_byte = reload_high_byte_q;
            `DMRT_OFF_CLKSEL: begin
                rd_byte[`DMRT_CKS_HIGH] = high_clock_select_q;
                rd_byte[`DMRT_CKS_LOW]  = low_clock_select_q;
            end
            `DMRT_OFF_IRQ_EN:   rd_byte[`DMRT_IE_TIMER] = timer_irq_enable_q;
            `DMRT_OFF_IRQ_STAT: rd_byte[1:0] = irq_stat_q;
            `DMRT_OFF_IRQ_MASK: rd_byte[1:0] = irq_mask_q;
            default:            rd_byte = 8'h00;
        endcase
    end

    // apb handshake: one wait state, answer in the second access cycle
    always @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            PREADY_OUT  <= 1'b0;
            PRDATA_OUT  <= 32'h0000_0000;
            PSLVERR_OUT <= 1'b0;
        end else if (CE_IN) begin
            if (PSEL_IN && PENABLE_IN && !PREADY_OUT) begin
                PREADY_OUT  <= 1'b1;
                PRDATA_OUT  <= {24'h00_0000, rd_byte};
                PSLVERR_OUT <= !addr_ok;
            end else begin
                PREADY_OUT  <= 1'b0;
                PSLVERR_OUT <= 1'b0;
            end
        end
    end

    // configuration registers
    always @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            ctrl_q              <= `DMRT_RST_BYTE;
            reload_low_byte_q   <= `DMRT_RST_BYTE;
            reload_high_byte_q  <= `DMRT_RST_BYTE;
            high_clock_select_q <= 1'b0;
            low_clock_select_q  <= 1'b0;
            timer_irq_enable_q  <= 1'b0;
            irq_mask_q          <= 2'b00;
        end else if (CE_IN && apb_wr) begin
            case (PADDR_IN)
                `DMRT_OFF_CTRL:   ctrl_q <= wb & `DMRT_CTRL_WMASK;
                `DMRT_OFF_RLD_LO: reload_low_byte_q  <= wb;
                `DMRT_OFF_RLD_HI: reload_high_byte_q <= wb;
                `DMRT_OFF_CLKSEL: begin
                    high_clock_select_q <= wb[`DMRT_CKS_HIGH];
                    low_clock_select_q  <= wb[`DMRT_CKS_LOW];
                end
                `DMRT_OFF_IRQ_EN:   timer_irq_enable_q <= wb[`DMRT_IE_TIMER];
                `DMRT_OFF_IRQ_MASK: irq_mask_q <= wb[1:0];
                default:            ctrl_q <= ctrl_q;
            endcase
        end
    end

    // low count byte: step, reload on split wrap or 16-bit overflow, software write otherwise
    always @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            count_low_byte_q <= `DMRT_RST_BYTE;
        end else if (CE_IN) begin
            if (ovf16) begin
                count_low_byte_q <= reload_word[7:0];
            end else if (split_mode_select && low_wrap) begin
                count_low_byte_q <= reload_low_byte_q;
            end else if (low_step) begin
                count_low_byte_q <= count_low_byte_q + 8'h01;
            end else if (wr_cnt_lo) begin
                count_low_byte_q <= wb;
            end
        end
    end

    // high count byte: carry in 16-bit mode, own tick in split mode
    always @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            count_high_byte_q <= `DMRT_RST_BYTE;
        end else if (CE_IN) begin
            if (ovf16) begin
                count_high_byte_q <= reload_word[15:8];
            end else if (!split_mode_select && low_wrap) begin
                count_high_byte_q <= count_word[15:8] + 8'h01;
            end else if (split_mode_select && high_wrap) begin
                count_high_byte_q <= reload_high_byte_q;
            end else if (high_step) begin
                count_high_byte_q <= count_high_byte_q + 8'h01;
            end else if (wr_cnt_hi) begin
                count_high_byte_q <= wb;
            end
        end
    end

    // overflow flags: hardware sets, only software clears, set wins
    always @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            high_overflow_flag_q <= 1'b0;
            low_overflow_flag_q  <= 1'b0;
        end else if (CE_IN) begin
            if (high_wrap) begin
                high_overflow_flag_q <= 1'b1;
            end else if (wr_ctrl) begin
                high_overflow_flag_q <= wb[`DMRT_CTRL_HOVF];
            end
            if (low_wrap) begin
                low_overflow_flag_q <= 1'b1;
            end else if (wr_ctrl) begin
                low_overflow_flag_q <= wb[`DMRT_CTRL_LOVF];
            end
        end
    end

    // sticky status, write one to clear, event wins over clear
    always @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            irq_stat_q <= 2'b00;
        end else if (CE_IN) begin
            irq_stat_q[`DMRT_ST_HOVF] <= high_wrap ||
                (irq_stat_q[`DMRT_ST_HOVF] &&
                 !(wr_stat && wb[`DMRT_ST_HOVF]));
            irq_stat_q[`DMRT_ST_LOVF] <= low_wrap ||
                (irq_stat_q[`DMRT_ST_LOVF] &&
                 !(wr_stat && wb[`DMRT_ST_LOVF]));
        end
    end

    // interrupt outputs, level, registered
    always @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            TIMER_IRQ_OUT  <= 1'b0;
            MASKED_IRQ_OUT <= 1'b0;
        end else if (CE_IN) begin
            TIMER_IRQ_OUT <= timer_irq_enable_q &&
                (high_overflow_flag_q ||
                 (low_overflow_irq_enable && low_overflow_flag_q));
            MASKED_IRQ_OUT <= |(irq_stat_q & irq_mask_q);
        end
    end
endmodule // dmrt_timer
